// file: src/flq_core.sv
/*
 * Fault latch qualifier: switching period, duty limit, ramp gating,
 * blanked and qualified off-time fault check, successive event count,
 * permanent latch-off.
 * Assumes analog comparators arrive as asynchronous levels and that
 * sys_rst is driven only by power-on reset.
 */
`timescale 1ns/1ps
// Notes on behaviour
// - Fault input is the protection pin comparator against its 3 V threshold.
// - After each turn-off, fault input ignored for 1 us blanking.
// - A fault high shorter than 600 ns is discarded.
// - Fault path latches off only after 4 successive validated events.
// - One count per switching cycle with event; an eventless cycle restarts.
// - Latched off stops all drive until power-on reset.
// - Compensation ramp connected only during on time.
// - On time limited to 80 percent of switching period.
// - Supply over-voltage stops pulses and latches, unless auto-recovery.
module flq_core #(
    parameter int PERIOD = flq_pkg::PERIOD_CYC,
    parameter bit AUTO_RECOVER_VCC = 1'b0
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic pin_fault_cmp,
    input wire logic vcc_ov_cmp,
    input wire logic loop_off_req,
    output logic gate_drive,
    output logic ramp_connect,
    output logic latched_off,
    output logic [2:0] event_count
);
    localparam int CW = flq_pkg::CNT_W;
    localparam logic [CW-1:0] PER_M1 = CW'(PERIOD - 1);
    localparam logic [CW-1:0] ON_MAX =
        CW'((PERIOD * flq_pkg::MAX_DUTY_PCT) / 100);
    localparam logic [CW-1:0] BLANK = CW'(flq_pkg::BLANK_CYC);
    localparam logic [CW-1:0] MIN_HI = CW'(flq_pkg::MIN_HIGH_CYC);
    localparam logic [2:0] EV_N = 3'(flq_pkg::EVENT_CNT);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [1:0] fsync_r, fsync_nxt, vsync_r, vsync_nxt, lsync_r, lsync_nxt;
    always_comb begin
        fsync_nxt = {fsync_r[0], pin_fault_cmp};
        vsync_nxt = {vsync_r[0], vcc_ov_cmp};
        lsync_nxt = {lsync_r[0], loop_off_req};
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            fsync_r <= 2'h0;
            vsync_r <= 2'h0;
            lsync_r <= 2'h0;
        end else begin
            fsync_r <= fsync_nxt;
            vsync_r <= vsync_nxt;
            lsync_r <= lsync_nxt;
        end
    end
    wire logic fault_s = fsync_r[1];
    wire logic vcc_ov_s = vsync_r[1];
    wire logic stop_req_s = lsync_r[1];

    // ************************************************************
    // Switching period and qualification
    // ************************************************************
    logic [CW-1:0] per_r, per_nxt, blank_r, blank_nxt, hi_r, hi_nxt;
    logic on_r, on_nxt, seen_r, seen_nxt, lat_r, lat_nxt;
    logic [2:0] ev_r, ev_nxt;
    logic period_end, checking;

    always_comb begin
        per_nxt = per_r;
        on_nxt = on_r;
        blank_nxt = blank_r;
        hi_nxt = hi_r;
        seen_nxt = seen_r;
        ev_nxt = ev_r;
        lat_nxt = lat_r;
        period_end = (per_r == PER_M1);
        checking = !on_r && (blank_r == BLANK);
        per_nxt = period_end ? '0 : per_r + CW'(1);
        // Start of period turns on, duty ceiling or loop turns off
        if (period_end) begin
            on_nxt = !lat_r && !stop_req_s;
        end else if (per_r + CW'(1) == ON_MAX || stop_req_s) begin
            on_nxt = 1'b0;
        end
        // Blanking counter restarts at every turn-off
        if (on_r) begin
            blank_nxt = '0;
        end else if (blank_r != BLANK) begin
            blank_nxt = blank_r + CW'(1);
        end
        // Continuous high width measured during off time only
        if (checking && fault_s) begin
            if (hi_r != MIN_HI) begin
                hi_nxt = hi_r + CW'(1);
            end
        end else begin
            hi_nxt = '0;
        end
        if (checking && fault_s && hi_r + CW'(1) >= MIN_HI) begin
            seen_nxt = 1'b1;
        end
        if (period_end) begin
            seen_nxt = 1'b0;
            if (seen_r || (checking && fault_s && hi_r + CW'(1) >= MIN_HI))
            begin
                if (ev_r != EV_N) begin
                    ev_nxt = ev_r + 3'h1;
                end
            end else begin
                ev_nxt = 3'h0;
            end
        end
        if (ev_r == EV_N) begin
            lat_nxt = 1'b1;
        end
        if (vcc_ov_s && !AUTO_RECOVER_VCC) begin
            lat_nxt = 1'b1;
        end
        if (lat_r) begin
            lat_nxt = 1'b1;
        end
        if (lat_r || vcc_ov_s) begin
            on_nxt = 1'b0;
        end
        // Closing event blocks the pulse that would start with it
        if (ev_nxt == EV_N) begin
            on_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            per_r <= '0;
            on_r <= 1'b0;
            blank_r <= '0;
            hi_r <= '0;
            seen_r <= 1'b0;
            ev_r <= 3'h0;
            lat_r <= 1'b0;
        end else begin
            per_r <= per_nxt;
            on_r <= on_nxt;
            blank_r <= blank_nxt;
            hi_r <= hi_nxt;
            seen_r <= seen_nxt;
            ev_r <= ev_nxt;
            lat_r <= lat_nxt;
        end
    end

    assign gate_drive = on_r;
    // Ramp follows the switch state exactly
    assign ramp_connect = on_r;
    assign latched_off = lat_r;
    assign event_count = ev_r;

    // ************************************************************
    // Checker helpers
    // ************************************************************
    // Off-time run counted from the pin, apart from the blanking
    // counter, so a slip in either one shows up in the checks
    logic [CW-1:0] offrun_r, offrun_nxt;
    always_comb begin
        offrun_nxt = offrun_r;
        if (gate_drive) begin
            offrun_nxt = '0;
        end else if (offrun_r != BLANK) begin
            offrun_nxt = offrun_r + CW'(1);
        end
    end
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            offrun_r <= '0;
        end else begin
            offrun_r <= offrun_nxt;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    a_latch_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
        lat_r |=> lat_r && !on_r)
        else $error("latch released or drive active");
    a_ramp_off_time: assert property (@(posedge core_clk)
        disable iff (sys_rst) ramp_connect == gate_drive)
        else $error("ramp connected in off time");
    a_duty_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
        on_r |-> per_r < ON_MAX)
        else $error("on time beyond duty ceiling");
    a_blank_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(on_r) |-> !checking [*8])
        else $error("fault checked inside blanking");
    a_four_latch: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ev_r == EV_N) |=> lat_r)
        else $error("no latch after event count");
    a_no_early_latch: assert property (@(posedge core_clk)
        disable iff (sys_rst)
        $rose(lat_r) |-> $past(ev_r) == EV_N || $past(vcc_ov_s))
        else $error("latched without cause");
    a_count_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
        period_end && !seen_r && !(checking && fault_s) |=> ev_r == 3'h0)
        else $error("count kept over eventless cycle");
    a_short_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(seen_r) |-> $past(hi_r) + CW'(1) >= MIN_HI)
        else $error("short pulse accepted");
    a_vcc_stop: assert property (@(posedge core_clk) disable iff (sys_rst)
        vcc_ov_s |=> !on_r)
        else $error("drive after supply over-voltage");
    a_off_latched: assert property (@(posedge core_clk)
        disable iff (sys_rst) latched_off |-> !gate_drive)
        else $error("drive while latched");
    a_count_steady: assert property (@(posedge core_clk)
        disable iff (sys_rst) !period_end |=> $stable(ev_r))
        else $error("count moved inside a period");
    a_blank_span: assert property (@(posedge core_clk)
        disable iff (sys_rst) checking |-> offrun_r == BLANK)
        else $error("fault checked before blanking ran out");
endmodule : flq_core

// file: inc/flq_pkg.sv
/*
 * Shared constants of the fault latch qualifier: timing figures in their
 * own units, derived cycle counts, switching period shape.
 * Assumes a 125 MHz core clock.
 */
package flq_pkg;
    // Core clock
    localparam int CLK_MHZ = 125;
    // Blanking after turn-off, in ns
    localparam int BLANK_NS = 1000;
    // Least fault high time, in ns
    localparam int MIN_HIGH_NS = 600;
    // Least time rounds up to whole cycles
    localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int MIN_HIGH_CYC = (MIN_HIGH_NS * CLK_MHZ + 999) / 1000;
    // Successive event cycles before latching
    localparam int EVENT_CNT = 4;
    // Maximum duty ratio in percent
    localparam int MAX_DUTY_PCT = 80;
    // Default switching period in core cycles (about 65 kHz)
    localparam int PERIOD_CYC = 1923;
    localparam int CNT_W = 12;
endpackage : flq_pkg

// file: sim/flq_fault_net.sv
/* Sensing network model: protection pin comparator output.
   Assumes gate_drive of flq_core and the core clock. */
`timescale 1ns/1ps
// ****************
// One pulse per off time
// ****************
module flq_fault_net (
    input wire logic core_clk,
    input wire logic gate_drive,
    input wire logic [11:0] start_dly,
    input wire logic [11:0] width,
    output logic pin_fault_cmp
);
    // Zero width keeps the pin below threshold
    initial begin
        pin_fault_cmp = 1'b0;
        forever begin
            @(negedge gate_drive);
            repeat (start_dly) @(posedge core_clk);
            #1 pin_fault_cmp = (width != 12'h0);
            repeat (width) @(posedge core_clk);
            #1 pin_fault_cmp = 1'b0;
        end
    end
endmodule : flq_fault_net

// file: sim/fault_latch_qualifier_test.sv
/* Testbench of flq_core with the sensing network model.
   Assumes a shortened period of 1200 cycles; its 240-cycle off time can still qualify a fault. */
`timescale 1ns/1ps
// ****************
// Bench
// ****************
module fault_latch_qualifier_test;
    localparam int PER = 1200;
    logic core_clk, sys_rst, pin_fault_cmp, vcc_ov_cmp, loop_off_req;
    logic gate_drive, ramp_connect, latched_off;
    logic [2:0] event_count;
    logic ar_gate, ar_latched;
    logic [11:0] start_dly, width;
    int mismatches, tests_run, on, bad;
    flq_core #(.PERIOD(PER), .AUTO_RECOVER_VCC(1'b0)) uut (
        .core_clk(core_clk), .sys_rst(sys_rst), .vcc_ov_cmp(vcc_ov_cmp),
        .pin_fault_cmp(pin_fault_cmp), .loop_off_req(loop_off_req),
        .gate_drive(gate_drive), .ramp_connect(ramp_connect),
        .latched_off(latched_off), .event_count(event_count));
    // Auto-recovery variant on the same inputs
    flq_core #(.PERIOD(PER), .AUTO_RECOVER_VCC(1'b1)) uut_ar (
        .core_clk(core_clk), .sys_rst(sys_rst), .vcc_ov_cmp(vcc_ov_cmp),
        .pin_fault_cmp(pin_fault_cmp), .loop_off_req(loop_off_req),
        .gate_drive(ar_gate), .ramp_connect(), .latched_off(ar_latched),
        .event_count());
    flq_fault_net net (.core_clk(core_clk), .gate_drive(gate_drive),
        .start_dly(start_dly), .width(width), .pin_fault_cmp(pin_fault_cmp));
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc
    task wait_rise;
        logic p;
        logic hit;
        p = gate_drive;
        hit = 1'b0;
        for (int i = 0; i < 3000 && !hit; i++) begin
            cyc(1);
            hit = (p === 1'b0) && (gate_drive === 1'b1);
            p = gate_drive;
        end
        chk(16'(hit), 16'h1);
    endtask : wait_rise
    task watch(input int n);
        on = 0;
        bad = 0;
        for (int i = 0; i < n; i++) begin
            if (gate_drive === 1'b1) on++;
            if (ramp_connect !== gate_drive) bad++;
            cyc(1);
        end
    endtask : watch
    task do_reset;
        sys_rst = 1'b1;
        cyc(20);
        chk(16'({gate_drive, latched_off, event_count}), 16'h0);
        sys_rst = 1'b0;
        wait_rise;
    endtask : do_reset
    task period(input logic [11:0] w, input logic [2:0] exp);
        width = w;
        wait_rise;
        chk(16'(event_count), 16'(exp));
        chk(16'(latched_off), 16'h0);
    endtask : period
    task final_report;
        $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    // Roughly three times the expected run
    initial begin
        #480000;
        mismatches++;
        final_report;
    end
    initial begin
        {vcc_ov_cmp, loop_off_req, width} = '0;
        start_dly = 12'h08c;
        do_reset;
        watch(PER);
        chk(16'(on), 16'(PER * 80 / 100));
        chk(16'(bad), 16'h0);
        cyc(100);
        loop_off_req = 1'b1;
        cyc(4);
        chk(16'({gate_drive, ramp_connect}), 16'h0);
        loop_off_req = 1'b0;
        wait_rise;
        period(12'h028, 3'h0);
        start_dly = 12'h000;
        period(12'h078, 3'h0);
        start_dly = 12'h08c;
        for (int i = 1; i < 4; i++) period(12'h05a, 3'(i));
        period(12'h000, 3'h0);
        for (int i = 1; i < 4; i++) period(12'h05a, 3'(i));
        cyc(PER - 2);
        watch(5);
        chk(16'(on), 16'h0);
        chk(16'({latched_off, event_count}), 16'h000c);
        watch(PER + 200);
        chk(16'({on[14:0], latched_off}), 16'h1);
        do_reset;
        vcc_ov_cmp = 1'b1;
        cyc(5);
        chk(16'({latched_off, gate_drive}), 16'h2);
        chk(16'({ar_latched, ar_gate}), 16'h0);
        vcc_ov_cmp = 1'b0;
        cyc(PER);
        chk(16'({latched_off, gate_drive}), 16'h2);
        chk(16'({ar_latched, ar_gate}), 16'h1);
        final_report;
    end
endmodule : fault_latch_qualifier_test
